// ==== core/pexv_core.sv ====
// Purpose: three-stage pipeline, flow change and exception vectoring
// Assumes: one bus master port; memory answers with bus_ack
// Notes: instruction decode is supplied from outside via exec_* inputs
`timescale 1ns/10ps
`include "pexv_defs.svh"
module pexv_core
  import pexv_pkg::*;
#(
  parameter int AW = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // memory bus
  output logic bus_req,
  output logic bus_write,
  output logic bus_data_space,
  output logic [AW-1:0] bus_addr,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack,
  // decode answers for the opcode in stage b
  input wire logic exec_done,
  input wire logic exec_opnd_8bit,
  input wire logic exec_opnd_from_a,
  input wire logic [7:0] exec_int_steps,
  input wire logic exec_flow,
  input wire logic exec_flow_temp,
  input wire logic [AW-1:0] exec_target,
  input wire logic exec_sync_exc,
  input wire logic [7:0] exec_sync_vec,
  input wire logic [7:0] ccr_in,
  // external exceptions
  input wire logic async_req,
  input wire logic async_ext_vec,
  input wire logic [7:0] async_vec_in,
  input wire logic [2:0] async_level,
  // pipeline view
  output logic [15:0] stage_a,
  output logic [15:0] stage_b,
  output logic [15:0] stage_c,
  output logic [7:0] exec_operand,
  output logic [AW-1:0] pc,
  output logic [AW-1:0] return_addr,
  output logic [3:0] program_bank_field,
  output logic [3:0] stack_bank_field,
  output logic [3:0] z_index_bank_field,
  output logic [15:0] stack_pointer,
  output logic [15:0] direct_page_index,
  output logic [15:0] total_clock_periods,
  output logic [15:0] program_access_periods,
  output logic [15:0] operand_access_periods,
  output logic [15:0] internal_operation_periods,
  output logic instr_complete,
  output logic exc_active
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [AW-1:0] vec_addr(input logic [7:0] num);
    vec_addr = {{(AW-9){1'b0}}, num, 1'b0};
  endfunction : vec_addr

  function automatic logic [7:0] autovector(input logic [2:0] lvl);
    if (lvl == 3'h0) begin
      autovector = `PEXV_VEC_SPURIOUS;
    end else begin
      autovector = `PEXV_VEC_AUTO_BASE + {5'h00, lvl};
    end
  endfunction : autovector

  ////////////////////////////////////////////////////////////////////////////
  pexv_state_t state_reg;
  logic async_s1_reg, async_s2_reg;
  logic [1:0] rst_idx_reg;
  logic [1:0] fill_cnt_reg;
  logic [8:0] int_cnt_reg;
  logic [3:0] bus_clk_reg;
  logic [7:0] xc_vec_reg;
  logic [7:0] xc_ccr_reg;
  logic [AW-1:0] xc_pc_reg;
  logic [AW-1:0] instr_addr_reg;
  logic bus_done;
  logic fetch_ack;

  // bus cycle ends on ack, but never before two clocks
  assign bus_done = bus_req && bus_ack && (bus_clk_reg >= `PEXV_MIN_BUS_CLKS - 4'h1);
  assign fetch_ack = bus_done && (state_reg == PEXV_FILL);
  assign exc_active = (state_reg == PEXV_XC_PUSH_PC) || (state_reg == PEXV_XC_PUSH_CCR) ||
                      (state_reg == PEXV_XC_VECTOR);

  // async request is a pin; two flops before use
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      async_s1_reg <= 1'b0;
      async_s2_reg <= 1'b0;
    end else if (clk_en) begin
      async_s1_reg <= async_req;
      async_s2_reg <= async_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus cycle length: whole clocks, stretched by slow ack
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_clk_reg <= 4'h0;
    end else if (clk_en) begin
      if (!bus_req || bus_done) begin
        bus_clk_reg <= 4'h0;
      end else if (bus_clk_reg != 4'hF) begin
        bus_clk_reg <= bus_clk_reg + 4'h1;
      end
    end
  end

  always_comb begin
    bus_req = 1'b0;
    bus_write = 1'b0;
    bus_data_space = 1'b0;
    bus_addr = '0;
    bus_wdata = 16'h0000;
    case (state_reg)
      PEXV_RST_FETCH: begin
        bus_req = 1'b1;
        bus_addr = vec_addr({6'h00, rst_idx_reg});
      end
      PEXV_FILL: begin
        bus_req = 1'b1;
        bus_addr = pc;
      end
      PEXV_EXEC_OPND: begin
        // once begun, an access is not dropped when decode changes
        bus_req = (bus_clk_reg != 4'h0) || !(exec_opnd_from_a || exec_opnd_8bit);
        bus_data_space = 1'b1;
        bus_addr = pc;
      end
      PEXV_XC_PUSH_PC: begin
        bus_req = 1'b1;
        bus_write = 1'b1;
        bus_data_space = 1'b1;
        bus_addr = {stack_bank_field, stack_pointer};
        bus_wdata = xc_pc_reg[15:0];
      end
      PEXV_XC_PUSH_CCR: begin
        bus_req = 1'b1;
        bus_write = 1'b1;
        bus_data_space = 1'b1;
        bus_addr = {stack_bank_field, stack_pointer};
        bus_wdata = {program_bank_field, 4'h0, xc_ccr_reg};
      end
      PEXV_XC_VECTOR: begin
        bus_req = 1'b1;
        bus_data_space = 1'b1;
        bus_addr = vec_addr(xc_vec_reg);
      end
      default: begin
        bus_req = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= PEXV_IDLE;
      rst_idx_reg <= 2'h0;
      fill_cnt_reg <= 2'h0;
      int_cnt_reg <= 9'h000;
      xc_vec_reg <= 8'h00;
      xc_ccr_reg <= 8'h00;
      xc_pc_reg <= '0;
    end else if (clk_en) begin
      case (state_reg)
        PEXV_IDLE: begin
          state_reg <= PEXV_RST_FETCH;
        end
        PEXV_RST_FETCH: begin
          if (bus_done) begin
            rst_idx_reg <= rst_idx_reg + 2'h1;
            if (rst_idx_reg == 2'h3) begin
              state_reg <= PEXV_FILL;
              fill_cnt_reg <= 2'h0;
            end
          end
        end
        PEXV_FILL: begin
          if (fetch_ack) begin
            fill_cnt_reg <= fill_cnt_reg + 2'h1;
            if (fill_cnt_reg == 2'h2) begin
              state_reg <= PEXV_EXEC_OPND;
            end
          end
        end
        PEXV_EXEC_OPND: begin
          // operand byte from a or b, or an extra data access
          if (bus_done || (bus_clk_reg == 4'h0 && (exec_opnd_from_a || exec_opnd_8bit))) begin
            int_cnt_reg <= 9'(exec_int_steps) * 9'(`PEXV_INT_STEP_CLKS);
            state_reg <= PEXV_EXEC_INT;
          end
        end
        PEXV_EXEC_INT: begin
          if (int_cnt_reg != 9'h000) begin
            int_cnt_reg <= int_cnt_reg - 9'h001;
          end else if (exec_done) begin
            if (exec_sync_exc) begin
              xc_vec_reg <= exec_sync_vec;
              xc_ccr_reg <= ccr_in;
              xc_pc_reg <= pc + `PEXV_SYNC_ADJ;
              state_reg <= PEXV_XC_PUSH_PC;
            end else if (async_s2_reg) begin
              xc_vec_reg <= async_ext_vec ? async_vec_in : autovector(async_level);
              xc_ccr_reg <= ccr_in;
              xc_pc_reg <= pc;
              state_reg <= PEXV_XC_PUSH_PC;
            end else if (exec_flow) begin
              state_reg <= PEXV_FLUSH;
            end else begin
              state_reg <= PEXV_EXEC_OPND;
            end
          end
        end
        PEXV_XC_PUSH_PC: begin
          if (bus_done) begin
            state_reg <= PEXV_XC_PUSH_CCR;
          end
        end
        PEXV_XC_PUSH_CCR: begin
          if (bus_done) begin
            state_reg <= PEXV_XC_VECTOR;
          end
        end
        PEXV_XC_VECTOR: begin
          if (bus_done) begin
            state_reg <= PEXV_FLUSH;
          end
        end
        PEXV_FLUSH: begin
          fill_cnt_reg <= 2'h0;
          state_reg <= PEXV_FILL;
        end
        default: begin
          state_reg <= PEXV_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pipeline stages
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage_a <= 16'h0000;
      stage_b <= 16'h0000;
      stage_c <= 16'h0000;
      exec_operand <= 8'h00;
      instr_complete <= 1'b0;
    end else if (clk_en) begin
      instr_complete <= 1'b0;
      if (state_reg == PEXV_FLUSH) begin
        stage_a <= 16'h0000;
        stage_b <= 16'h0000;
      end else if (fetch_ack) begin
        stage_a <= bus_rdata;
        stage_b <= stage_a;
      end else if (state_reg == PEXV_EXEC_OPND) begin
        exec_operand <= exec_opnd_from_a ? stage_a[7:0] : stage_b[7:0];
      end else if (state_reg == PEXV_EXEC_INT && int_cnt_reg == 9'h000 && exec_done) begin
        stage_c <= stage_b;
        stage_b <= stage_a;
        instr_complete <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter, banks and stack
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc <= '0;
      return_addr <= '0;
      instr_addr_reg <= '0;
      program_bank_field <= 4'h0;
      stack_bank_field <= 4'h0;
      z_index_bank_field <= 4'h0;
      stack_pointer <= 16'h0000;
      direct_page_index <= 16'h0000;
    end else if (clk_en) begin
      if (state_reg == PEXV_RST_FETCH && bus_done) begin
        case (rst_idx_reg)
          2'h0: begin
            z_index_bank_field <= bus_rdata[11:8];
            stack_bank_field <= bus_rdata[7:4];
            program_bank_field <= bus_rdata[3:0];
          end
          2'h1: pc <= {program_bank_field, bus_rdata};
          2'h2: stack_pointer <= bus_rdata;
          default: direct_page_index <= bus_rdata;
        endcase
      end else if (fetch_ack) begin
        pc <= pc + `PEXV_SYNC_ADJ;
      end else if (state_reg == PEXV_EXEC_INT && int_cnt_reg == 9'h000 && exec_done &&
                   !exec_sync_exc && !async_s2_reg) begin
        instr_addr_reg <= pc - `PEXV_PC_LEAD;
        if (exec_flow) begin
          pc <= exec_target;
          program_bank_field <= exec_target[19:16];
          if (exec_flow_temp) begin
            return_addr <= pc;
          end
        end
      end else if ((state_reg == PEXV_XC_PUSH_PC || state_reg == PEXV_XC_PUSH_CCR) &&
                   bus_done) begin
        stack_pointer <= stack_pointer - 16'h0002;
      end else if (state_reg == PEXV_XC_VECTOR && bus_done) begin
        program_bank_field <= 4'h0;
        pc <= {4'h0, bus_rdata};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle accounting for the current instruction
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      program_access_periods <= 16'h0000;
      operand_access_periods <= 16'h0000;
      internal_operation_periods <= 16'h0000;
    end else if (clk_en) begin
      if (instr_complete) begin
        program_access_periods <= 16'h0000;
        operand_access_periods <= 16'h0000;
        internal_operation_periods <= 16'h0000;
      end else if (state_reg == PEXV_FILL) begin
        program_access_periods <= program_access_periods + 16'h0001;
      end else if (state_reg == PEXV_EXEC_OPND) begin
        operand_access_periods <= operand_access_periods + 16'h0001;
      end else if (state_reg == PEXV_EXEC_INT && int_cnt_reg != 9'h000) begin
        // counted per clock; each step lasts two
        internal_operation_periods <= internal_operation_periods + 16'h0001;
      end
    end
  end

  assign total_clock_periods = program_access_periods + operand_access_periods +
                               internal_operation_periods;

endmodule : pexv_core

// ==== core/pexv_defs.svh ====
// Purpose: constants for the pipeline and exception vectoring core
// Assumes: 16-bit words, 20-bit extended addresses
// Notes: offsets are byte addresses in bank zero
`ifndef PEXV_DEFS_SVH
`define PEXV_DEFS_SVH
`define PEXV_PC_LEAD 20'h00006
`define PEXV_SYNC_ADJ 20'h00002
`define PEXV_TABLE_BYTES 20'h00200
`define PEXV_PREDEF_VECTORS 52
`define PEXV_USER_VECTORS 200
`define PEXV_RST_BANKS 20'h00000
`define PEXV_RST_PC 20'h00002
`define PEXV_RST_SP 20'h00004
`define PEXV_RST_IZ 20'h00006
`define PEXV_VEC_BKPT 8'h04
`define PEXV_VEC_BUSERR 8'h05
`define PEXV_VEC_SWI 8'h06
`define PEXV_VEC_ILLEGAL 8'h07
`define PEXV_VEC_DIVZERO 8'h08
`define PEXV_VEC_UNINIT 8'h0F
`define PEXV_VEC_AUTO_BASE 8'h10
`define PEXV_VEC_SPURIOUS 8'h18
`define PEXV_VEC_USER_FIRST 8'h38
`define PEXV_MIN_BUS_CLKS 4'h2
`define PEXV_INT_STEP_CLKS 8'h02
`endif

// ==== core/pexv_pkg.sv ====
// Purpose: types for the pipeline and exception vectoring core
// Assumes: pexv_defs.svh supplies the numbers
// Notes: none
package pexv_pkg;
  typedef enum logic [2:0] {
    PEXV_SPACE_PROGRAM,
    PEXV_SPACE_DATA
  } pexv_space_t;
  typedef enum logic [4:0] {
    PEXV_IDLE,
    PEXV_RST_FETCH,
    PEXV_FILL,
    PEXV_EXEC_OPND,
    PEXV_EXEC_INT,
    PEXV_XC_PUSH_PC,
    PEXV_XC_PUSH_CCR,
    PEXV_XC_VECTOR,
    PEXV_FLUSH
  } pexv_state_t;
  typedef enum logic [1:0] {
    PEXV_OP_NONE,
    PEXV_OP_READ,
    PEXV_OP_WRITE
  } pexv_op_t;
endpackage : pexv_pkg

// ==== sim/pexv_core_asserts.sv ====
// Purpose: port checks on pexv_core
// Assumes: clk_en held high
// Notes: bound at the foot of this file
`timescale 1ns/10ps
module pexv_core_asserts
  import pexv_pkg::*;
#(
  parameter int AW = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic bus_data_space,
  input wire logic bus_ack,
  input wire logic [AW-1:0] bus_addr,
  // state view
  input wire logic [15:0] stack_pointer,
  input wire logic [3:0] program_bank_field,
  input wire logic [15:0] total_clock_periods,
  input wire logic [15:0] program_access_periods,
  input wire logic [15:0] operand_access_periods,
  input wire logic [15:0] internal_operation_periods,
  input wire logic exc_active,
  input wire logic instr_complete
);
  logic [3:0] held_reg;
  logic done;
  // a first-clock ack does not end an access
  assign done = bus_req && bus_ack && held_reg != 4'h0;
  always_ff @(posedge clk) begin
    if (!reset_n || done || !bus_req) begin
      held_reg <= 4'h0;
    end else if (held_reg != 4'hF) begin
      held_reg <= held_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_bus_two_clks: assert property ($rose(bus_req) |=> bus_req)
    else $error("bus cycle ended after one clock");
  a_addr_stands: assert property (bus_req && !done |=> bus_req && $stable(bus_addr))
    else $error("bus address moved before completion");
  a_reset_fetch: assert property ($rose(reset_n) |-> ##[0:2] (bus_req && bus_addr == '0 && !bus_data_space))
    else $error("reset fetch not at word zero");
  a_vector_table: assert property (exc_active && bus_req && !bus_write && bus_data_space |-> bus_addr < 'h200 && !bus_addr[0])
    else $error("vector read outside table");
  a_push_at_sp: assert property (bus_req && bus_write |-> bus_addr[15:0] == stack_pointer)
    else $error("push not at stack pointer");
  a_sp_step: assert property (done && bus_write |=> stack_pointer == $past(stack_pointer) - 16'h0002)
    else $error("stack pointer not lowered by two");
  a_total_sum: assert property (total_clock_periods == program_access_periods + operand_access_periods + internal_operation_periods)
    else $error("total periods not the sum");
  a_internal_even: assert property (instr_complete |-> !internal_operation_periods[0])
    else $error("internal periods odd");
  a_bank_clear: assert property ($fell(exc_active) |-> program_bank_field == 4'h0)
    else $error("program bank not cleared");
endmodule : pexv_core_asserts
bind pexv_core pexv_core_asserts #(.AW(AW)) u_chk (.*);

// ==== sim/pexv_core_bench.sv ====
// Purpose: self-checking bench for pexv_core
// Assumes: operand and step decode answers are random levels; exec_done held high
// Notes: handler of vector v sits at 0x1000 plus 16 v
`timescale 1ns/10ps
module pexv_core_bench;
  import pexv_pkg::*;
  typedef struct packed {
    logic wr;
    logic ds;
    logic [19:0] a;
    logic [15:0] d;
  } pexv_acc_t;
  logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, exec_done = 1'b1;
  logic exec_opnd_8bit = 1'b0, exec_opnd_from_a = 1'b0, exec_flow = 1'b0;
  logic exec_flow_temp = 1'b0, exec_sync_exc = 1'b0, async_req = 1'b0, async_ext_vec = 1'b0;
  logic [7:0] exec_int_steps = 8'h00, exec_sync_vec = 8'h00, ccr_in = 8'h00;
  logic [7:0] async_vec_in = 8'h00, exec_operand, uv;
  logic [15:0] exp_sp = 16'h0F00, exp_pc = 16'h0606;
  logic [3:0] exp_pk = 4'h5;
  logic [2:0] async_level = 3'h0;
  logic [19:0] exec_target = 20'h00000, bus_addr, pc, return_addr;
  logic bus_req, bus_write, bus_data_space, bus_ack, done, instr_complete, exc_active;
  logic [15:0] bus_wdata, bus_rdata, stage_a, stage_b, stage_c, stack_pointer;
  logic [15:0] direct_page_index, total_clock_periods, program_access_periods;
  logic [15:0] operand_access_periods, internal_operation_periods;
  logic [3:0] program_bank_field, stack_bank_field, z_index_bank_field;
  int seed = 37506, num_errors = 0, checked = 0, cycles = 0;
  pexv_acc_t log_q[$];
  pexv_core dut (.*);
  pexv_mem mem (.clk, .reset_n, .bus_req, .bus_write, .bus_addr, .bus_wdata, .bus_rdata,
    .bus_ack, .done);
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (done) log_q.push_back({bus_write, bus_data_space, bus_addr, bus_write ? bus_wdata : bus_rdata});
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  //////////////////////////////////////////////////////////////
  task chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // next completed access of one kind, from index i on
  task next_acc(inout int i, input logic wr, input logic ds, output pexv_acc_t e);
    e = '1;
    repeat (600) begin
      while (i < log_q.size() && !(log_q[i].wr === wr && log_q[i].ds === ds)) i++;
      if (i < log_q.size()) break;
      @(negedge clk);
    end
    if (i < log_q.size()) e = log_q[i];
    i++;
  endtask : next_acc
  task exc(input logic sy, input logic ext, input logic [7:0] v, input logic [2:0] lv,
      input logic [7:0] ev);
    pexv_acc_t e;
    int i;
    logic [7:0] cc;
    cc = 8'($random(seed));
    @(posedge clk);
    exec_sync_exc <= sy;
    exec_sync_vec <= v;
    async_req <= !sy;
    async_ext_vec <= ext;
    async_vec_in <= v;
    async_level <= lv;
    ccr_in <= cc;
    exec_int_steps <= 8'($random(seed)) & 8'h03;
    exec_opnd_8bit <= 1'($random(seed));
    exec_opnd_from_a <= 1'($random(seed));
    @(negedge clk);
    repeat (400) if (exc_active !== 1'b1) @(negedge clk);
    i = log_q.size();
    @(posedge clk);
    exec_sync_exc <= 1'b0;
    async_req <= 1'b0;
    next_acc(i, 1'b1, 1'b1, e);
    chk(e.a, {4'h2, exp_sp});
    chk({4'h0, e.d}, {4'h0, exp_pc + (sy ? 16'h0002 : 16'h0000)});
    next_acc(i, 1'b1, 1'b1, e);
    chk(e.a, {4'h2, exp_sp - 16'h0002});
    chk({4'h0, e.d}, {4'h0, exp_pk, 4'h0, cc});
    next_acc(i, 1'b0, 1'b1, e);
    chk(e.a, {11'h000, ev, 1'b0});
    next_acc(i, 1'b0, 1'b0, e);
    chk(e.a, {8'h01, ev, 4'h0});
    exp_sp = exp_sp - 16'h0004;
    exp_pk = 4'h0;
    exp_pc = 16'h1006 + {4'h0, ev, 4'h0};
    repeat (400) if (exc_active !== 1'b0) @(negedge clk);
    $display("test vector %h done", ev);
  endtask : exc
  initial begin
    pexv_acc_t e;
    int i;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    i = 0;
    for (int k = 0; k < 4; k++) begin
      next_acc(i, 1'b0, 1'b0, e);
      chk(e.a, 20'(2 * k));
    end
    for (int k = 0; k < 3; k++) begin
      next_acc(i, 1'b0, 1'b0, e);
      chk(e.a, 20'(20'h30400 + 2 * k));
    end
    chk(pc, 20'h30406);
    chk({8'h00, z_index_bank_field, stack_bank_field, program_bank_field}, 20'h00123);
    chk({4'h0, stage_a}, 20'h04A4A);
    chk({4'h0, stage_b}, 20'h04A25);
    chk({4'h0, stack_pointer}, 20'h00F00);
    chk({4'h0, direct_page_index}, 20'h01234);
    $display("test reset done");
    @(posedge clk);
    exec_flow <= 1'b1;
    exec_flow_temp <= 1'b1;
    exec_target <= 20'h50600;
    // two completions so at least one ran with the jump decoded
    for (int n = 0; n < 2; n++) begin
      @(negedge clk);
      repeat (400) if (instr_complete !== 1'b1) @(negedge clk);
    end
    i = log_q.size();
    @(posedge clk);
    exec_flow <= 1'b0;
    exec_flow_temp <= 1'b0;
    next_acc(i, 1'b0, 1'b0, e);
    chk(e.a, 20'h50600);
    chk(return_addr, 20'h50606);
    $display("test flow done");
    for (int v = 4; v <= 8; v++) exc(1'b1, 1'b0, 8'(v), 3'h0, 8'(v));
    for (int l = 0; l < 8; l++) exc(1'b0, 1'b0, 8'h00, 3'(l), l == 0 ? 8'h18 : 8'(16 + l));
    for (int k = 0; k < 6; k++) begin
      uv = k == 0 ? 8'h38 : k == 1 ? 8'hFF : 8'(56 + {$random(seed)} % 200);
      exc(1'b0, 1'b1, uv, 3'h7, uv);
    end
    finish_test();
  end
endmodule : pexv_core_bench

// ==== sim/pexv_mem.sv ====
// Purpose: memory answering the pexv_core bus
// Assumes: 8K words, byte address bits 13:1
// Notes: may ack in the first clock, which the core must ignore
`timescale 1ns/10ps
module pexv_mem (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bus
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [19:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_ack,
  output logic done
);
  logic [15:0] mem [0:8191];
  logic [3:0] cyc_reg = 4'h0;
  logic [3:0] lat_reg = 4'h1;
  int seed = 37506;
  initial begin
    for (int k = 0; k < 8192; k++) begin
      mem[k] = k < 256 ? {4'h1, 8'(k), 4'h0} : 16'(k * 37);
    end
    mem[0] = 16'h0123;
    mem[1] = 16'h0400;
    mem[2] = 16'h0F00;
    mem[3] = 16'h1234;
  end
  assign bus_ack = bus_req && cyc_reg >= lat_reg;
  assign done = bus_ack && cyc_reg != 4'h0;
  // inverted while not acking, so an early sample cannot match
  assign bus_rdata = bus_ack ? mem[bus_addr[13:1]] : ~mem[bus_addr[13:1]];
  always @(posedge clk) begin
    if (!reset_n || done || !bus_req) begin
      cyc_reg <= 4'h0;
    end else begin
      cyc_reg <= cyc_reg + 4'h1;
    end
    if (done) begin
      lat_reg <= 4'({$random(seed)} % 4); // slow memory stretch
    end
    if (done && bus_write) begin
      mem[bus_addr[13:1]] <= bus_wdata;
    end
  end
endmodule : pexv_mem
